// ### bench/tb_top.sv
// Bench for one port's FIFO control block, driven through the host model.
// Assumes the default port address and sixteen-byte FIFOs.
`timescale 1ns/1ps
module tb_top;
  localparam logic [15:0] A = 16'h00C2;
  logic clk = 1'b0, reset_n = 1'b0, rx_irq_enable = 1'b0, rx_timeout = 1'b0;
  logic rx_in_valid = 1'b0, rx_pop = 1'b0, tx_in_valid = 1'b0, tx_out_ready = 1'b0;
  logic [7:0] rx_in_data = 8'h00, tx_in_data = 8'h00;
  logic [15:0] io_addr;
  logic [7:0] io_wdata, io_rdata, rx_out_data, tx_out_data;
  logic io_wr, io_rd, rx_in_ready, rx_out_valid, tx_in_ready, tx_out_valid;
  logic rx_logic_reset_n, tx_logic_reset_n, fifo_mode_flag, rx_irq;
  int num_errors = 0, n_tests = 0;
  logic [7:0] lvl [4] = '{8'h01, 8'h04, 8'h08, 8'h0E};
  always #2.5 clk = ~clk;
  ufc_host host (.clk(clk), .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd));
  ufc_top DUT (.clk(clk), .reset_n(reset_n), .io_addr(io_addr), .io_wdata(io_wdata),
    .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata), .rx_irq_enable(rx_irq_enable),
    .rx_timeout(rx_timeout), .rx_in_valid(rx_in_valid), .rx_in_data(rx_in_data),
    .rx_in_ready(rx_in_ready), .rx_pop(rx_pop), .rx_out_data(rx_out_data),
    .rx_out_valid(rx_out_valid), .tx_in_valid(tx_in_valid), .tx_in_data(tx_in_data),
    .tx_in_ready(tx_in_ready), .tx_out_valid(tx_out_valid), .tx_out_data(tx_out_data),
    .tx_out_ready(tx_out_ready), .rx_logic_reset_n(rx_logic_reset_n),
    .tx_logic_reset_n(tx_logic_reset_n), .fifo_mode_flag(fifo_mode_flag), .rx_irq(rx_irq));
  // Counts one comparison and reports a mismatch
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic complete_run();
    if (num_errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Burst of n received bytes; valid held until each is accepted
  task automatic push(input int n, input logic [7:0] b);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      rx_in_valid <= 1'b1;
      rx_in_data <= b + 8'(i);
      @(negedge clk);
      while (rx_in_ready !== 1'b1) @(negedge clk);
    end
    @(posedge clk);
    rx_in_valid <= 1'b0;
  endtask
  // Pops n bytes, checking order
  task automatic drain(input int n, input logic [7:0] b);
    @(posedge clk);
    rx_pop <= 1'b1;
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      chk("rx_out_data", b + 8'(i), rx_out_data);
      @(posedge clk);
    end
    rx_pop <= 1'b0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Watchdog cuts a hang short
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    complete_run();
  end
  initial begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    settle(1);
    chk("flag", 8'h00, fifo_mode_flag);
    chk("rx_rst_n", 8'h00, rx_logic_reset_n);
    chk("tx_rst_n", 8'h00, tx_logic_reset_n);
    host.rd(A);
    chk("ident", 8'h01, io_rdata);
    host.wr(A, 8'h01);
    settle(1);
    chk("flag", 8'h01, fifo_mode_flag);
    chk("rx_ready", 8'h00, rx_in_ready);
    host.rd(A);
    chk("ident", 8'h81, io_rdata);
    host.wr(A, 8'h07);
    host.wr(16'h00D2, 8'h00);
    settle(1);
    chk("rx_rst_n", 8'h01, rx_logic_reset_n);
    chk("tx_rst_n", 8'h01, tx_logic_reset_n);
    @(posedge clk);
    rx_irq_enable <= 1'b1;
    // Every trigger level: quiet one byte short, raised at the level
    for (int t = 0; t < 4; t++) begin
      host.wr(A, {2'(t), 6'h07});
      push(int'(lvl[t]) - 1, 8'h10);
      settle(3);
      chk("irq_below", 8'h00, rx_irq);
      push(1, 8'h10 + lvl[t] - 8'h01);
      settle(3);
      chk("irq_level", 8'h01, rx_irq);
      host.rd(A);
      chk("ident", 8'h84, io_rdata);
      if (t < 3) host.wr(A, 8'h01);
      settle(2);
      if (t < 3) chk("rx_valid", 8'h00, rx_out_valid);
    end
    push(2, 8'h1E);
    settle(1);
    chk("full_ready", 8'h00, rx_in_ready);
    drain(16, 8'h10);
    settle(1);
    chk("empty", 8'h00, rx_out_valid);
    host.wr(A, 8'h07);
    rx_irq_enable <= 1'b0;
    push(1, 8'h33);
    settle(3);
    chk("irq_masked", 8'h00, rx_irq);
    drain(1, 8'h33);
    rx_irq_enable <= 1'b1;
    rx_timeout <= 1'b1;
    host.rd(A);
    chk("ident_to", 8'h8C, io_rdata);
    rx_timeout <= 1'b0;
    host.wr(A, 8'hC6);
    push(1, 8'h55);
    settle(3);
    chk("flag", 8'h00, fifo_mode_flag);
    chk("irq_byp", 8'h01, rx_irq);
    chk("byp_ready", 8'h00, rx_in_ready);
    host.wr(A, 8'h07);
    @(posedge clk);
    tx_in_valid <= 1'b1;
    tx_in_data <= 8'hA5;
    @(posedge clk);
    tx_in_valid <= 1'b0;
    settle(1);
    chk("tx_valid", 8'h01, tx_out_valid);
    chk("tx_data", 8'hA5, tx_out_data);
    host.wr(A, 8'h03);
    settle(1);
    chk("tx_rst_n", 8'h00, tx_logic_reset_n);
    chk("tx_valid", 8'h00, tx_out_valid);
    chk("tx_ready_off", 8'h00, tx_in_ready);
    host.wr(A, 8'h07);
    settle(1);
    chk("tx_valid", 8'h00, tx_out_valid);
    chk("tx_ready_on", 8'h01, tx_in_ready);
    // One byte through the transmit FIFO, taken by the shifter
    @(posedge clk);
    tx_in_valid <= 1'b1;
    tx_in_data <= 8'h5A;
    tx_out_ready <= 1'b1;
    @(posedge clk);
    tx_in_valid <= 1'b0;
    settle(1);
    chk("tx_data", 8'h5A, tx_out_data);
    @(posedge clk);
    settle(1);
    chk("tx_drained", 8'h00, tx_out_valid);
    complete_run();
  end
endmodule // tb_top

// ### bench/ufc_host.sv
// Host model: single-byte I/O writes and reads on the port's register address.
// Assumes the block samples the strobes on the rising edge of clk.
`timescale 1ns/1ps
module ufc_host (
  input wire logic clk,
  output logic [15:0] io_addr,
  output logic [7:0] io_wdata,
  output logic io_wr,
  output logic io_rd
);
  // Idle bus at time zero
  initial begin
    io_addr = 16'hFFFF;
    io_wdata = 8'h00;
    io_wr = 1'b0;
    io_rd = 1'b0;
  end
  // Write strobe for one edge; idle bus then shows inverted values
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    io_addr <= a;
    io_wdata <= d;
    io_wr <= 1'b1;
    @(posedge clk);
    io_wr <= 1'b0;
    io_addr <= ~a;
    io_wdata <= ~d;
    @(posedge clk);
  endtask
  // Read strobe for one edge; data stands afterwards until the next read
  task automatic rd(input logic [15:0] a);
    @(posedge clk);
    io_addr <= a;
    io_rd <= 1'b1;
    @(posedge clk);
    io_rd <= 1'b0;
    io_addr <= ~a;
    @(posedge clk);
  endtask
endmodule // ufc_host

// ### hdl/ufc_cfg.svh
// Constants for the FIFO control block: addresses, field positions, levels, codes.
// Assumes inclusion by bare name from the package and the design file.
`ifndef UFC_CFG_SVH
`define UFC_CFG_SVH
`define UFC_PORT0_ADDR 16'h00C2
`define UFC_PORT1_ADDR 16'h00D2
`define UFC_CTRL_RESET 8'h00
`define UFC_BIT_FIFO_EN 0
`define UFC_BIT_RX_EN 1
`define UFC_BIT_TX_EN 2
`define UFC_THR_HI 7
`define UFC_THR_LO 6
`define UFC_IDENT_FLAG_BIT 7
`define UFC_LVL_ONE 5'h01
`define UFC_LVL_FOUR 5'h04
`define UFC_LVL_EIGHT 5'h08
`define UFC_LVL_FOURTEEN 5'h0E
`define UFC_CODE_RX_DATA 3'h2
`define UFC_CODE_TIMEOUT 3'h6
`define UFC_CODE_NONE 3'h0
`define UFC_FIFO_DEPTH 16
`endif

// ### hdl/ufc_pkg.sv
// Types shared by the FIFO control block.
// Assumes the constants header sits beside it.
`include "ufc_cfg.svh"
package ufc_pkg;
  // Receive trigger field encodings
  typedef enum logic [1:0] {
    UFC_THR_1,
    UFC_THR_4,
    UFC_THR_8,
    UFC_THR_14
  } ufc_thr_t;
endpackage

// ### hdl/ufc_top.sv
// FIFO control register of one serial port, with its receive and transmit FIFOs.
// Assumes an I/O bus on clk with one-cycle strobes and shifters on the same clock.
// What this block does
// R1: Write-only control, zero reset, shares ident address
// R2: Trigger field picks 1, 4, 8, 14 bytes
// R3: Trigger applies only in FIFO mode
// R4: Transmit enable persists; transmit only while set
// R5: Transmit enable low resets FIFO and shifter
// R6: Receive enable persists; accept only while set
// R7: Receive enable low resets FIFO and receiver
// R8: FIFO enable selects FIFO or single buffer
// R9: Software sets FIFO enable before path enables
// R10: Ident top bit mirrors FIFO mode
// R11: Receive interrupts pass only when enabled
// R12: Each FIFO holds sixteen bytes
`timescale 1ns/1ps
`include "ufc_cfg.svh"

module ufc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `UFC_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clr,
  input wire logic single,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH]; // Storage
  logic [AW-1:0] wp_ff, nxt_wp; // Write pointer
  logic [AW-1:0] rp_ff, nxt_rp; // Read pointer
  logic [AW:0] cnt_ff, nxt_cnt; // Fill level
  logic push; // Entry accepted
  logic pop; // Entry taken
  logic [AW:0] cap; // Depth in use

  // Single buffer when FIFOs are bypassed
  assign cap = single ? (AW+1)'(1) : (AW+1)'(DEPTH); // R8
  assign in_ready = cnt_ff < cap;
  assign out_valid = cnt_ff != '0;
  assign out_data = mem_ff[rp_ff];
  assign count = cnt_ff;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointer and level update, clear wins
  always_comb begin
    nxt_wp = wp_ff;
    nxt_rp = rp_ff;
    nxt_cnt = cnt_ff;
    if (clr) begin
      nxt_wp = '0;
      nxt_rp = '0;
      nxt_cnt = '0;
    end else begin
      if (push) nxt_wp = wp_ff + 1'b1;
      if (pop) nxt_rp = rp_ff + 1'b1;
      if (push && !pop) nxt_cnt = cnt_ff + 1'b1;
      else if (pop && !push) nxt_cnt = cnt_ff - 1'b1;
    end
  end

  // Register pointers and level
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
    end else begin
      wp_ff <= nxt_wp;
      rp_ff <= nxt_rp;
      cnt_ff <= nxt_cnt;
    end
  end

  // Storage write, no reset needed on data
  always_ff @(posedge clk) begin
    if (push && !clr) mem_ff[wp_ff] <= in_data;
  end
endmodule // ufc_fifo

module ufc_top import ufc_pkg::*; #(
  parameter logic [15:0] PORT_ADDR = `UFC_PORT0_ADDR,
  parameter int DEPTH = `UFC_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [15:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_wr,
  input wire logic io_rd,
  output logic [7:0] io_rdata,
  input wire logic rx_irq_enable,
  input wire logic rx_timeout,
  input wire logic rx_in_valid,
  input wire logic [7:0] rx_in_data,
  output logic rx_in_ready,
  input wire logic rx_pop,
  output logic [7:0] rx_out_data,
  output logic rx_out_valid,
  input wire logic tx_in_valid,
  input wire logic [7:0] tx_in_data,
  output logic tx_in_ready,
  output logic tx_out_valid,
  output logic [7:0] tx_out_data,
  input wire logic tx_out_ready,
  output logic rx_logic_reset_n,
  output logic tx_logic_reset_n,
  output logic fifo_mode_flag,
  output logic rx_irq
);
  localparam int CW = $clog2(DEPTH) + 1;
  logic [7:0] ctrl_ff, nxt_ctrl; // FIFO control register
  logic [7:0] rdata_ff, nxt_rdata; // Ident read data
  logic rx_irq_ff, nxt_rx_irq; // Gated receive interrupt
  logic sel; // Address hit
  logic fifo_mode_enable; // Mode bit
  logic rx_path_enable; // Receive enable bit
  logic tx_path_enable; // Transmit enable bit
  ufc_thr_t rx_threshold_select; // Trigger field
  logic [4:0] level; // Bytes needed to trigger
  logic [CW-1:0] rx_count; // Receive fill
  logic thr_hit; // Fill reached trigger
  logic [2:0] code; // Ident status code
  logic rx_in_ok; // Receive accept qualifier
  logic tx_out_ok; // Transmit drain qualifier
  logic tx_fifo_valid; // Transmit FIFO has data
  logic rx_fifo_ready; // Receive FIFO has room
  logic tx_in_ok; // Transmit accept qualifier
  logic tx_fifo_ready; // Transmit FIFO has room

  assign sel = io_addr == PORT_ADDR;
  assign fifo_mode_enable = ctrl_ff[`UFC_BIT_FIFO_EN];
  assign rx_path_enable = ctrl_ff[`UFC_BIT_RX_EN];
  assign tx_path_enable = ctrl_ff[`UFC_BIT_TX_EN];
  assign rx_threshold_select = ufc_thr_t'(ctrl_ff[`UFC_THR_HI:`UFC_THR_LO]);

  // Trigger level, forced to one byte when bypassed
  always_comb begin
    level = `UFC_LVL_ONE;
    if (fifo_mode_enable) begin // R3
      unique case (rx_threshold_select) // R2
        UFC_THR_1: level = `UFC_LVL_ONE;
        UFC_THR_4: level = `UFC_LVL_FOUR;
        UFC_THR_8: level = `UFC_LVL_EIGHT;
        UFC_THR_14: level = `UFC_LVL_FOURTEEN;
      endcase
    end
  end
  assign thr_hit = 32'(rx_count) >= 32'(level); // R2

  // Ident status code, data ready ahead of timeout
  always_comb begin
    code = `UFC_CODE_NONE;
    if (rx_irq_enable && thr_hit) code = `UFC_CODE_RX_DATA; // R11
    else if (rx_irq_enable && rx_timeout) code = `UFC_CODE_TIMEOUT; // R11
  end

  // Register writes and ident reads at the shared address
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_rdata = rdata_ff;
    if (sel && io_wr) nxt_ctrl = io_wdata; // R1 R4 R6
    if (sel && io_rd) begin
      nxt_rdata = 8'h00;
      nxt_rdata[`UFC_IDENT_FLAG_BIT] = fifo_mode_enable; // R10
      nxt_rdata[3:1] = code; // R1
      nxt_rdata[0] = code == `UFC_CODE_NONE;
    end
    nxt_rx_irq = rx_irq_enable && (thr_hit || rx_timeout); // R11
  end

  // Register state; path resets follow the enable bits
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_ff <= `UFC_CTRL_RESET; // R1
      rdata_ff <= 8'h00;
      rx_irq_ff <= 1'b0;
      rx_logic_reset_n <= 1'b0;
      tx_logic_reset_n <= 1'b0;
      fifo_mode_flag <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      rdata_ff <= nxt_rdata;
      rx_irq_ff <= nxt_rx_irq;
      rx_logic_reset_n <= nxt_ctrl[`UFC_BIT_RX_EN]; // R7
      tx_logic_reset_n <= nxt_ctrl[`UFC_BIT_TX_EN]; // R5
      fifo_mode_flag <= nxt_ctrl[`UFC_BIT_FIFO_EN]; // R10
    end
  end
  assign io_rdata = rdata_ff;
  assign rx_irq = rx_irq_ff;

  // Receive FIFO, cleared while receive is disabled
  assign rx_in_ok = rx_path_enable && rx_in_valid; // R6
  assign rx_in_ready = rx_path_enable && rx_fifo_ready;
  ufc_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_rx_fifo ( // R12
    .clk(clk),
    .reset_n(reset_n),
    .clr(!rx_path_enable), // R7
    .single(!fifo_mode_enable), // R8
    .in_valid(rx_in_ok),
    .in_data(rx_in_data),
    .in_ready(rx_fifo_ready),
    .out_valid(rx_out_valid),
    .out_data(rx_out_data),
    .out_ready(rx_pop),
    .count(rx_count)
  );

  // Transmit FIFO, drained only while transmit is enabled
  assign tx_out_ok = tx_path_enable && tx_out_ready; // R4
  assign tx_out_valid = tx_path_enable && tx_fifo_valid;
  // Refuse writes while held in reset; a byte accepted at the edge of the write that clears the enable is still dropped
  assign tx_in_ok = tx_path_enable && tx_in_valid; // R5
  assign tx_in_ready = tx_path_enable && tx_fifo_ready; // R5
  ufc_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_tx_fifo ( // R12
    .clk(clk),
    .reset_n(reset_n),
    .clr(!tx_path_enable), // R5
    .single(!fifo_mode_enable), // R8
    .in_valid(tx_in_ok),
    .in_data(tx_in_data),
    .in_ready(tx_fifo_ready),
    .out_valid(tx_fifo_valid),
    .out_data(tx_out_data),
    .out_ready(tx_out_ok),
    .count()
  );

  // Checks
  a_ctrl_write: assert property (@(posedge clk) disable iff (!reset_n) // R1
    sel && io_wr |=> ctrl_ff == $past(io_wdata)) else $error("control write lost");
  a_ctrl_hold: assert property (@(posedge clk) disable iff (!reset_n) // R4
    !(sel && io_wr) |=> $stable(ctrl_ff)) else $error("control changed");
  // Read data holds the mode seen at the read edge, even if a write lands there too
  a_flag_mirror: assert property (@(posedge clk) disable iff (!reset_n) // R10
    sel && io_rd |=> io_rdata[7] == $past(fifo_mode_flag)) else $error("mode flag wrong");
  a_bypass_level: assert property (@(posedge clk) disable iff (!reset_n) // R3
    !fifo_mode_enable && rx_irq_enable && rx_count == CW'(1) |=> rx_irq)
    else $error("bypass trigger");
  a_level_14: assert property (@(posedge clk) disable iff (!reset_n) // R2
    fifo_mode_enable && rx_threshold_select == UFC_THR_14 && !rx_timeout
    && rx_count == CW'(13) |=> !rx_irq) else $error("early trigger");
  a_irq_gate: assert property (@(posedge clk) disable iff (!reset_n) // R11
    !rx_irq_enable |=> !rx_irq) else $error("irq not gated");
  a_tx_reset: assert property (@(posedge clk) disable iff (!reset_n) // R5
    !tx_path_enable |-> !tx_out_valid && !tx_logic_reset_n) else $error("tx not held");
  a_tx_refuse: assert property (@(posedge clk) disable iff (!reset_n) // R5
    !tx_path_enable |-> !tx_in_ready) else $error("tx accepted");
  a_rx_reset: assert property (@(posedge clk) disable iff (!reset_n) // R7
    !rx_path_enable |=> !rx_out_valid) else $error("rx not cleared");
  a_single_buf: assert property (@(posedge clk) disable iff (!reset_n) // R8
    !fifo_mode_enable && rx_out_valid |-> !rx_fifo_ready) else $error("bypass depth");
  a_rx_accept: assert property (@(posedge clk) disable iff (!reset_n) // R6
    !rx_path_enable |-> !rx_in_ready) else $error("rx accepted");
  c_fifo_full: cover property (@(posedge clk) rx_count == CW'(DEPTH));
  c_level_fire: cover property (@(posedge clk) fifo_mode_enable && $rose(rx_irq));
  c_tx_send: cover property (@(posedge clk) tx_out_valid && tx_out_ready);
endmodule // ufc_top
